// file: gpcn_pkg.sv
// package: register map, field positions and reset values of the port block
package gpcn_pkg;
  localparam int          PIN_W         = 16;
  localparam int          ADDR_W        = 16;
  localparam logic [15:0] OFF_DIR       = 16'h6210;
  localparam logic [15:0] OFF_PIN       = 16'h6220;
  localparam logic [15:0] OFF_LAT       = 16'h6230;
  localparam logic [15:0] OFF_ODC       = 16'h6240;
  localparam logic [15:0] OFF_PU        = 16'h6250;
  localparam logic [15:0] OFF_PD        = 16'h6260;
  localparam logic [15:0] OFF_CCON      = 16'h6270;
  localparam logic [15:0] OFF_CEN       = 16'h6280;
  localparam logic [15:0] OFF_CSTAT     = 16'h6290;
  localparam logic [15:0] OFF_ANSEL     = 16'h6200;
  localparam logic [1:0]  ALIAS_BASE    = 2'h0;
  localparam logic [1:0]  ALIAS_CLEAR   = 2'h1;
  localparam logic [1:0]  ALIAS_SET     = 2'h2;
  localparam logic [1:0]  ALIAS_FLIP    = 2'h3;
  localparam int          CCON_ON_BIT   = 15;
  localparam int          CCON_IDLE_BIT = 13;
  localparam logic [15:0] CCON_MASK     = 16'ha000;
  localparam logic [15:0] RST_ONES      = 16'hffff;
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage : gpcn_pkg

// file: gpcn_port.sv
// gpio port with change notification behind an AHB-Lite slave
// What this block does
// - direction one is input, zero drives latch
// - every pin is input after reset
// - latch register reads and writes latch
// - pin register reads pins, writes latch
// - open-drain bit makes pin pull-low only
// - analog select resets to all ones
// - analog pins read zero from pin register
// - change detected and interrupt raised while idle
// - change interrupt gated per pin by enable
// - status set on change since pin read
// - pull-up and pull-down enabled independently
// - clear set invert aliases touch ones only
// - alias reads return undefined, here zero
// - aliases at base plus 4, 8, 12
// - unimplemented bits read zero
`timescale 1ns/1ps
module gpcn_port #(
  parameter int PIN_W = 16
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [PIN_W-1:0]  pin_in,
  output logic      [PIN_W-1:0]  pin_out,
  output logic      [PIN_W-1:0]  pin_oe_n,
  output logic      [PIN_W-1:0]  pullup_en,
  output logic      [PIN_W-1:0]  pulldown_en,
  output logic      [PIN_W-1:0]  analog_en,
  output logic                   change_irq
);
  localparam int W = gpcn_pkg::PIN_W;

  if (PIN_W != W) begin : g_bad_width
    $error("gpcn_port: PIN_W must equal %0d", W);
  end

  typedef struct packed {
    logic [W-1:0]  dir;
    logic [W-1:0]  lat;
    logic [W-1:0]  odc;
    logic [W-1:0]  pu;
    logic [W-1:0]  pd;
    logic [W-1:0]  ansel;
    logic [W-1:0]  cen;
    logic [W-1:0]  cstat;
    logic [W-1:0]  ccon;
    logic [W-1:0]  sync1;
    logic [W-1:0]  sync2;
    logic [W-1:0]  seen;
    logic          dph_wr;
    logic [15:0]   dph_addr;
    logic [31:0]   rdata;
    logic [W-1:0]  pout;
    logic [W-1:0]  poe_n;
    logic          irq;
  } gpcn_state_s;

  gpcn_state_s st_r;
  gpcn_state_s st_nxt;

  // apply a base write or an alias operation to one register
  function automatic logic [W-1:0] gpcn_apply(input logic [W-1:0] cur, input logic [1:0] op,
                                               input logic [W-1:0] wd);
    logic [W-1:0] res;
    res = cur;
    unique case (op)
      gpcn_pkg::ALIAS_BASE: res = wd;
      gpcn_pkg::ALIAS_CLEAR: res = cur & ~wd;
      gpcn_pkg::ALIAS_SET:  res = cur | wd;
      gpcn_pkg::ALIAS_FLIP: res = cur ^ wd;
    endcase
    return res;
  endfunction : gpcn_apply

  // base offset of an address, aliases stripped
  function automatic logic [15:0] gpcn_base(input logic [15:0] a);
    return {a[15:4], 4'h0};
  endfunction : gpcn_base

  logic          addr_ph;
  logic [15:0]   wa_base;
  logic [1:0]    wa_op;
  logic [W-1:0]  wd;
  logic [W-1:0]  pin_view;
  logic [W-1:0]  changed;
  logic [15:0]   ra_base;

  always_comb begin
    addr_ph  = hsel && hready && (htrans == gpcn_pkg::HTRANS_NONSEQ);
    wa_base  = gpcn_base(st_r.dph_addr);
    wa_op    = st_r.dph_addr[3:2];
    wd       = hwdata[W-1:0];
    pin_view = st_r.sync2 & ~st_r.ansel;
    changed  = st_r.sync2 ^ st_r.seen;
    ra_base  = gpcn_base(haddr[15:0]);
    st_nxt   = st_r;

    st_nxt.sync1 = pin_in;
    st_nxt.sync2 = st_r.sync1;

    // change detect runs whatever the idle flag says; the pin sampler never stops
    st_nxt.cstat = st_r.cstat | (changed & st_r.cen);

    st_nxt.dph_wr = addr_ph && hwrite;
    if (addr_ph) begin
      st_nxt.dph_addr = haddr[15:0];
    end

    if (st_r.dph_wr) begin
      unique case (wa_base)
        gpcn_pkg::OFF_DIR:   st_nxt.dir   = gpcn_apply(st_r.dir, wa_op, wd);
        gpcn_pkg::OFF_PIN:   st_nxt.lat   = gpcn_apply(st_r.lat, wa_op, wd);
        gpcn_pkg::OFF_LAT:   st_nxt.lat   = gpcn_apply(st_r.lat, wa_op, wd);
        gpcn_pkg::OFF_ODC:   st_nxt.odc   = gpcn_apply(st_r.odc, wa_op, wd);
        gpcn_pkg::OFF_PU:    st_nxt.pu    = gpcn_apply(st_r.pu, wa_op, wd);
        gpcn_pkg::OFF_PD:    st_nxt.pd    = gpcn_apply(st_r.pd, wa_op, wd);
        gpcn_pkg::OFF_ANSEL: st_nxt.ansel = gpcn_apply(st_r.ansel, wa_op, wd);
        gpcn_pkg::OFF_CCON:  st_nxt.ccon  = gpcn_apply(st_r.ccon, wa_op, wd) & gpcn_pkg::CCON_MASK;
        gpcn_pkg::OFF_CEN:   st_nxt.cen   = gpcn_apply(st_r.cen, wa_op, wd);
        default: ;
      endcase
    end

    // read data is sampled at the address phase and stands in the data phase
    st_nxt.rdata = 32'h0000_0000;
    if (addr_ph && !hwrite && (haddr[3:2] == gpcn_pkg::ALIAS_BASE)) begin
      unique case (ra_base)
        gpcn_pkg::OFF_DIR:   st_nxt.rdata[W-1:0] = st_r.dir;
        gpcn_pkg::OFF_PIN:   st_nxt.rdata[W-1:0] = pin_view;
        gpcn_pkg::OFF_LAT:   st_nxt.rdata[W-1:0] = st_r.lat;
        gpcn_pkg::OFF_ODC:   st_nxt.rdata[W-1:0] = st_r.odc;
        gpcn_pkg::OFF_PU:    st_nxt.rdata[W-1:0] = st_r.pu;
        gpcn_pkg::OFF_PD:    st_nxt.rdata[W-1:0] = st_r.pd;
        gpcn_pkg::OFF_ANSEL: st_nxt.rdata[W-1:0] = st_r.ansel;
        gpcn_pkg::OFF_CCON:  st_nxt.rdata[W-1:0] = st_r.ccon;
        gpcn_pkg::OFF_CEN:   st_nxt.rdata[W-1:0] = st_r.cen;
        gpcn_pkg::OFF_CSTAT: st_nxt.rdata[W-1:0] = st_r.cstat;
        default:             st_nxt.rdata = 32'h0000_0000;
      endcase
      if (ra_base == gpcn_pkg::OFF_PIN) begin
        // a pin read re-arms detection; a change in this very cycle still sets status
        st_nxt.seen  = st_r.sync2;
        st_nxt.cstat = (st_r.sync1 ^ st_r.sync2) & st_r.cen;
      end
    end

    for (int i = 0; i < W; i++) begin
      if (st_r.dir[i]) begin
        st_nxt.poe_n[i] = 1'b1;
        st_nxt.pout[i]  = 1'b0;
      end else if (st_r.odc[i]) begin
        st_nxt.poe_n[i] = st_r.lat[i];
        st_nxt.pout[i]  = 1'b0;
      end else begin
        st_nxt.poe_n[i] = 1'b0;
        st_nxt.pout[i]  = st_r.lat[i];
      end
    end

    st_nxt.irq = st_r.ccon[gpcn_pkg::CCON_ON_BIT] && |(st_r.cstat & st_r.cen);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r       <= '0;
      st_r.dir   <= gpcn_pkg::RST_ONES;
      st_r.poe_n <= gpcn_pkg::RST_ONES;
      st_r.ansel <= gpcn_pkg::RST_ONES;
      st_r.ccon  <= gpcn_pkg::RST_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    hrdata      = st_r.rdata;
    hreadyout   = 1'b1;
    hresp       = 1'b0;
    pin_out     = st_r.pout;
    pin_oe_n    = st_r.poe_n;
    pullup_en   = st_r.pu;
    pulldown_en = st_r.pd;
    analog_en   = st_r.ansel;
    change_irq  = st_r.irq;
  end
endmodule : gpcn_port

// file: gpcn_port_monitor.sv
// checker: bus answers and pin relations of the port block
`timescale 1ns/1ps
module gpcn_port_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire logic [15:0] pullup_en,
  input wire logic [15:0] analog_en,
  input wire logic        change_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire tk = hsel && hready && htrans == gpcn_pkg::HTRANS_NONSEQ;
  wire rd = tk && !hwrite;
  property p_bus_ok; hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready okay");
  property p_top_zero; hrdata[31:16] == 16'h0000; endproperty
  a_top_zero: assert property (p_top_zero) else $error("upper read bits set");
  property p_reset_in; $rose(hresetn) |-> &pin_oe_n && &analog_en && !change_irq; endproperty
  a_reset_in: assert property (p_reset_in) else $error("reset state wrong");
  property p_alias_zero; rd && haddr[3:2] != 2'h0 |=> hrdata == 32'h00000000; endproperty
  a_alias_zero: assert property (p_alias_zero) else $error("alias read not zero");
  property p_analog; rd && haddr[15:0] == gpcn_pkg::OFF_PIN |=> (hrdata[15:0] & analog_en) == 16'h0000; endproperty
  a_analog: assert property (p_analog) else $error("analog pin read high");
  property p_drive; (pin_out & pin_oe_n) == 16'h0000; endproperty
  a_drive: assert property (p_drive) else $error("undriven pin shows level");
  property p_dir_in;
    (tk && hwrite && haddr[15:0] == gpcn_pkg::OFF_DIR) ##1 (hwdata[15:0] == 16'hffff) |-> ##[1:2] &pin_oe_n;
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("input direction not released");
  property p_pullup;
    (tk && hwrite && haddr[15:0] == gpcn_pkg::OFF_PU) |=> ##1 pullup_en == $past(hwdata[15:0]);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up enable wrong");
  cover property (rd && haddr[15:0] == gpcn_pkg::OFF_PIN);
  cover property ($rose(change_irq));
  cover property (tk && hwrite && haddr[3:2] == 2'h3);
endmodule : gpcn_port_monitor

bind gpcn_port gpcn_port_monitor i_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .pin_out, .pin_oe_n, .pullup_en, .analog_en, .change_irq);

// file: gpcn_pins.sv
// board-side pin model: drivers, pulls and floating pins
`timescale 1ns/1ps
module gpcn_pins (
  input  wire logic        hclk,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  input  wire logic [15:0] pullup_en,
  input  wire logic [15:0] pulldown_en,
  input  wire logic [15:0] ext_en,
  input  wire logic [15:0] ext_val,
  output logic      [15:0] pin_in
);
  logic [15:0] flt_r = 16'h5a5a;
  // floating pins wander every cycle
  always @(posedge hclk) flt_r <= ~flt_r;
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                | (pin_oe_n & ~ext_en & (pullup_en | (~pulldown_en & flt_r)));
endmodule : gpcn_pins

// file: gpcn_port_tb.sv
// self-checking bench of the port block with board model
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module gpcn_port_tb;
  logic        hclk = 0, hresetn = 0, hwrite = 0, dph = 0, irq, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, s = 32'd57836, ex, exq[$];
  logic [15:0] ext_en = 16'h0, ext_val = 16'h0, pin_in, pin_out, pin_oe_n, pu, pd, an, lat, m;
  int          num_errors = 0, n_tests = 0, cyc = 0;
  always #50 hclk = ~hclk;
  gpcn_port i_dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(gpcn_pkg::HSIZE_WORD), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe_n, .pullup_en(pu),
    .pulldown_en(pd), .analog_en(an), .change_irq(irq));
  gpcn_pins i_pins (.hclk, .pin_out, .pin_oe_n, .pullup_en(pu), .pulldown_en(pd), .ext_en, .ext_val, .pin_in);
  function logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    htrans <= gpcn_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {16'h0000, a};
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
  endtask : xfer
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    exq.push_back({16'h0000, e});
    xfer(1'b0, a, rnd());
  endtask : rd
  task give_verdict();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  always @(posedge hclk) begin
    dph <= hresetn && htrans == gpcn_pkg::HTRANS_NONSEQ && !hwrite;
    cyc++;
    if (dph) begin
      ex = exq.pop_front();
      `CHK("hrdata", ex, hrdata)
    end
    if (cyc == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("oe_n", 16'hffff, pin_oe_n)
    `CHK("analog", 16'hffff, an)
    rd(gpcn_pkg::OFF_DIR, 16'hffff);
    rd(16'h6300, 16'h0000);
    lat = 16'(rnd());
    xfer(1'b1, gpcn_pkg::OFF_PIN, {rnd(), lat});
    rd(gpcn_pkg::OFF_LAT, lat);
    for (int k = 1; k < 4; k++) begin
      m = 16'(rnd());
      xfer(1'b1, gpcn_pkg::OFF_LAT + 16'(4 * k), {16'hffff, m});
      lat = k == 1 ? lat & ~m : k == 2 ? lat | m : lat ^ m;
      rd(gpcn_pkg::OFF_LAT, lat);
      rd(gpcn_pkg::OFF_LAT + 16'(4 * k), 16'h0000);
    end
    xfer(1'b1, gpcn_pkg::OFF_ANSEL, 32'h0);
    xfer(1'b1, gpcn_pkg::OFF_DIR, 32'h0);
    repeat (2) @(posedge hclk);
    `CHK("oe_n", 16'h0000, pin_oe_n)
    `CHK("out", lat, pin_out)
    repeat (2) @(posedge hclk);
    rd(gpcn_pkg::OFF_PIN, lat);
    xfer(1'b1, gpcn_pkg::OFF_ODC, 32'hffff);
    repeat (2) @(posedge hclk);
    `CHK("od_out", 16'h0000, pin_out)
    `CHK("od_oe", lat, pin_oe_n)
    xfer(1'b1, gpcn_pkg::OFF_ODC, 32'h0);
    xfer(1'b1, gpcn_pkg::OFF_DIR, 32'hffff);
    ext_en <= 16'hffff;
    ext_val <= 16'hffff;
    m = 16'(rnd());
    xfer(1'b1, gpcn_pkg::OFF_PU, {16'h0000, m});
    xfer(1'b1, gpcn_pkg::OFF_PD, {16'h0000, ~m});
    rd(gpcn_pkg::OFF_PIN, 16'hffff);
    `CHK("pulls", {m, ~m}, {pu, pd})
    xfer(1'b1, gpcn_pkg::OFF_ANSEL, 32'hffff);
    rd(gpcn_pkg::OFF_PIN, 16'h0000);
    xfer(1'b1, gpcn_pkg::OFF_ANSEL, 32'h0);
    ext_val <= 16'h0000;
    repeat (4) @(posedge hclk);
    rd(gpcn_pkg::OFF_PIN, 16'h0000);
    xfer(1'b1, gpcn_pkg::OFF_CEN, 32'h0008);
    xfer(1'b1, gpcn_pkg::OFF_CCON, 32'hffff);
    rd(gpcn_pkg::OFF_CCON, 16'ha000);
    ext_val <= 16'h0020;
    repeat (6) @(posedge hclk);
    `CHK("irq", 1'b0, irq)
    ext_val <= 16'h0028;
    repeat (6) @(posedge hclk);
    `CHK("irq", 1'b1, irq)
    rd(gpcn_pkg::OFF_CSTAT, 16'h0008);
    rd(gpcn_pkg::OFF_PIN, 16'h0028);
    repeat (3) @(posedge hclk);
    `CHK("irq", 1'b0, irq)
    give_verdict();
  end
endmodule : gpcn_port_tb
